// *** hw/host_port_pkg.sv ***
package host_port_pkg;

  localparam int AXI_AW = 12;
  localparam logic [AXI_AW-1:0] ADDR_ENDIAN_CTRL = 12'h000;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 12'h004;

  // Endian control fields
  localparam int BIT_LOW_LANE_SWAP = 0;
  localparam int BIT_HIGH_LANE_SWAP = 1;
  // Status fields
  localparam int BIT_INIT_PENDING = 0;
  localparam int BIT_WIDTH16 = 1;
  localparam int BIT_ILLEGAL = 2;
  localparam int BIT_SWAP_ACTIVE = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic RST_WIDTH16 = 1'b1;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANES_OFF = 2'h3;

  typedef enum logic [1:0] {
    HP_IDLE = 2'h0,
    HP_RD_WAIT = 2'h1,
    HP_RD_DRIVE = 2'h3
  } host_state_e;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic width_strap;
    logic [12:0] addr;
    logic [15:0] data;
  } host_in_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } mem_req_s;

endpackage : host_port_pkg

// *** hw/host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_port
  import host_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire host_in_s host_i,
  output logic [15:0] data_o,
  output logic [1:0] data_oe_n,
  output logic pull_up_hi,
  output logic init_pending_n,
  input wire logic boot_code_image_done,
  input wire logic protection_structures_done,
  output mem_req_s mem_o,
  input wire logic [15:0] mem_rdata
);

  typedef struct packed {
    host_in_s sync1;
    host_in_s sync2;
    logic prev_sel;
    logic prev_we_n;
    logic strap_taken;
    logic width16;
    logic high_lane_swap;
    logic low_lane_swap;
    logic boot_done;
    logic prot_done;
    logic illegal;
    logic rd_a0;
    logic rd_lat;
    host_state_e fsm;
    logic [15:0] dout;
    logic [1:0] doe_n;
    mem_req_s mem;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  function automatic logic [15:0] lane_swap(input logic [15:0] d);
    lane_swap = {d[7:0], d[15:8]};
  endfunction : lane_swap

  // Flash words to host lanes; upper lane idle in byte mode
  function automatic logic [15:0] route_rd(input logic [15:0] m,
      input logic w16, input logic a0, input logic swp);
    if (w16) begin
      route_rd = swp ? lane_swap(m) : m;
    end else if (a0) begin
      route_rd = {8'hFF, m[15:8]};
    end else begin
      route_rd = {8'hFF, m[7:0]};
    end
  endfunction : route_rd

  logic swap_active;
  logic wr_fire;
  logic rd_start;
  logic wr_end;
  logic [31:0] status_word;

  assign swap_active = st_r.high_lane_swap & st_r.low_lane_swap
                       & st_r.width16;
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign wr_fire = (st_r.aw_got || s_axi_awvalid)
                   && (st_r.w_got || s_axi_wvalid) && !st_r.bvalid;
  assign rd_start = !st_r.sync2.ce_n && !st_r.sync2.oe_n && !st_r.prev_sel;
  assign wr_end = !st_r.sync2.ce_n && st_r.sync2.we_n && !st_r.prev_we_n;
  assign status_word = {28'h0000000, swap_active, st_r.illegal,
                        st_r.width16, !(st_r.boot_done && st_r.prot_done)};

  always_comb begin
    logic [AXI_AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic ill_ev;
    st_nxt = st_r;
    ill_ev = 1'b0;
    wa = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
    wd = st_r.w_got ? st_r.wdata : s_axi_wdata;
    ws = st_r.w_got ? st_r.wstrb : s_axi_wstrb;
    // Pins pass two flops before use
    st_nxt.sync1 = host_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev_sel = !st_r.sync2.ce_n && !st_r.sync2.oe_n;
    st_nxt.prev_we_n = st_r.sync2.we_n || st_r.sync2.ce_n;
    // Strap resampled every idle cycle without a host read select while init is pending, from the second cycle after reset
    if (!st_r.strap_taken) begin
      st_nxt.strap_taken = 1'b1;
    end
    if (st_r.strap_taken && !st_nxt.prev_sel && st_r.fsm == HP_IDLE
        && !(st_r.boot_done && st_r.prot_done)) begin
      st_nxt.width16 = st_r.sync2.width_strap;
    end
    if (boot_code_image_done) begin
      st_nxt.boot_done = 1'b1;
    end
    if (protection_structures_done) begin
      st_nxt.prot_done = 1'b1;
    end
    st_nxt.mem.req = 1'b0;
    st_nxt.mem.we = 1'b0;

    case (st_r.fsm)
      HP_IDLE: begin
        st_nxt.doe_n = LANES_OFF;
        if (st_r.boot_done && st_r.prot_done) begin
          if ((rd_start || wr_end) && st_r.sync2.addr[0] && st_r.width16)
          begin
            st_nxt.illegal = 1'b1;
            ill_ev = 1'b1;
          end else if (rd_start) begin
            st_nxt.mem.req = 1'b1;
            st_nxt.mem.addr = st_r.sync2.addr[12:1];
            st_nxt.mem.be = LANE_BOTH;
            st_nxt.rd_a0 = st_r.sync2.addr[0];
            st_nxt.fsm = HP_RD_WAIT;
          end else if (wr_end) begin
            st_nxt.mem.req = 1'b1;
            st_nxt.mem.we = 1'b1;
            st_nxt.mem.addr = st_r.sync2.addr[12:1];
            if (st_r.width16) begin
              st_nxt.mem.be = LANE_BOTH;
              st_nxt.mem.wdata = swap_active
                ? lane_swap(st_r.sync2.data) : st_r.sync2.data;
            end else begin
              st_nxt.mem.be = st_r.sync2.addr[0] ? LANE_HIGH : LANE_LOW;
              st_nxt.mem.wdata = {st_r.sync2.data[7:0],
                                  st_r.sync2.data[7:0]};
            end
          end
        end
      end
      HP_RD_WAIT: begin
        // Memory word arrives one cycle after the request
        if (!st_r.rd_lat) begin
          st_nxt.rd_lat = 1'b1;
        end else begin
          st_nxt.rd_lat = 1'b0;
          st_nxt.dout = route_rd(mem_rdata, st_r.width16, st_r.rd_a0,
                                 swap_active);
          st_nxt.doe_n = st_r.width16 ? 2'h0 : 2'h2;
          st_nxt.fsm = HP_RD_DRIVE;
        end
      end
      HP_RD_DRIVE: begin
        if (st_r.sync2.ce_n || st_r.sync2.oe_n) begin
          st_nxt.doe_n = LANES_OFF;
          st_nxt.fsm = HP_IDLE;
        end
      end
      default: begin
        st_nxt.fsm = HP_IDLE;
      end
    endcase

    // Register bus, write side
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (wa[AXI_AW-1:2] == ADDR_ENDIAN_CTRL[AXI_AW-1:2]) begin
        if (ws[0]) begin
          st_nxt.low_lane_swap = wd[BIT_LOW_LANE_SWAP];
          st_nxt.high_lane_swap = wd[BIT_HIGH_LANE_SWAP];
        end
      end else if (wa[AXI_AW-1:2] == ADDR_STATUS[AXI_AW-1:2]) begin
        // A new illegal access in the same cycle wins over the clear
        if (ws[0] && wd[BIT_ILLEGAL] && !ill_ev)
        begin
          st_nxt.illegal = 1'b0;
        end
      end else begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Register bus, read side
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      if (s_axi_araddr[AXI_AW-1:2] == ADDR_ENDIAN_CTRL[AXI_AW-1:2]) begin
        st_nxt.rdata = {30'h00000000, st_r.high_lane_swap,
                        st_r.low_lane_swap};
      end else if (s_axi_araddr[AXI_AW-1:2] == ADDR_STATUS[AXI_AW-1:2])
      begin
        st_nxt.rdata = status_word;
      end else begin
        st_nxt.rdata = 32'h00000000;
        st_nxt.rresp = RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.sync1 <= '1;
      st_r.sync2 <= '1;
      st_r.prev_we_n <= 1'b1;
      st_r.width16 <= RST_WIDTH16;
      st_r.doe_n <= LANES_OFF;
      st_r.fsm <= HP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign data_o = st_r.dout;
  assign data_oe_n = st_r.doe_n;
  assign pull_up_hi = !st_r.width16;
  assign init_pending_n = st_r.boot_done && st_r.prot_done;
  assign mem_o = st_r.mem;

  sequence s_rd_resolve;
    st_r.fsm == HP_RD_WAIT && st_r.rd_lat;
  endsequence

  property p_init_release;
    @(posedge aclk) disable iff (!aresetn)
    (boot_code_image_done || st_r.boot_done)
      && (protection_structures_done || st_r.prot_done) |=> init_pending_n;
  endproperty
  a_init_release: assert property (p_init_release)
    else $error("init pending not released after downloads");

  property p_init_hold;
    @(posedge aclk) disable iff (!aresetn)
    !init_pending_n |=> !mem_o.req;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("flash access while init pending");

  property p_swap_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_resolve and swap_active |=>
      data_o == {$past(mem_rdata[7:0]), $past(mem_rdata[15:8])};
  endproperty
  a_swap_read: assert property (p_swap_read)
    else $error("lane swap not applied");

  property p_word_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_resolve and st_r.width16 && !swap_active |=>
      data_o == $past(mem_rdata) && data_oe_n == 2'h0;
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("16-bit read wrong");

  property p_even_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_resolve and !st_r.width16 && !st_r.rd_a0 |=>
      data_o[7:0] == $past(mem_rdata[7:0]) && data_oe_n == 2'h2;
  endproperty
  a_even_read: assert property (p_even_read)
    else $error("even byte read wrong");

  property p_odd_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_resolve and !st_r.width16 && st_r.rd_a0 |=>
      data_o[7:0] == $past(mem_rdata[15:8]) && data_oe_n == 2'h2;
  endproperty
  a_odd_read: assert property (p_odd_read)
    else $error("odd byte read wrong");

  property p_illegal_combo;
    @(posedge aclk) disable iff (!aresetn)
    st_r.fsm == HP_IDLE && init_pending_n && rd_start
      && st_r.sync2.addr[0] && st_r.width16 |=> !mem_o.req && st_r.illegal;
  endproperty
  a_illegal_combo: assert property (p_illegal_combo)
    else $error("illegal combination not refused");

  property p_byte_write;
    @(posedge aclk) disable iff (!aresetn)
    mem_o.req && mem_o.we && !st_r.width16 |->
      mem_o.be != LANE_BOTH && mem_o.wdata[7:0] == mem_o.wdata[15:8];
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write not steered");

  property p_word_fetch;
    @(posedge aclk) disable iff (!aresetn)
    mem_o.req && !mem_o.we |-> mem_o.be == LANE_BOTH ##1 s_rd_resolve;
  endproperty
  a_word_fetch: assert property (p_word_fetch)
    else $error("fetch not whole word");

  property p_axi_read;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_axi_read: assert property (p_axi_read)
    else $error("read answer missing");

endmodule : host_port
`default_nettype wire

// *** verification/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import host_port_pkg::*;
(
  input wire logic aclk,
  input wire logic strap,
  input wire logic init_pending_n,
  input wire logic pull_up_hi,
  input wire logic [15:0] data_o,
  input wire logic [1:0] data_oe_n,
  output var host_in_s host_o
);
  logic ce_n = 1'b1;
  logic oe_n = 1'b1;
  logic we_n = 1'b1;
  logic drv = 1'b0;
  logic [12:0] addr = 13'h0000;
  logic [15:0] wr_d = 16'h0000;
  logic [15:0] drift = 16'h0000;
  // Undriven lines toggle, except the upper lane held at FF under pull_up_hi, so stale data never passes
  always @(posedge aclk) drift <= ~drift;
  always_comb begin
    host_o = '{ce_n, oe_n, we_n, strap, addr, drv ? wr_d : drift};
    if (!data_oe_n[0]) host_o.data[7:0] = data_o[7:0];
    if (!data_oe_n[1]) host_o.data[15:8] = data_o[15:8];
    else if (pull_up_hi) host_o.data[15:8] = 8'hFF;
  end
  // No wait input: polls init_pending_n, and reads poll data_oe_n for up to 30 cycles
  task automatic ready_wait();
    int n;
    n = 0;
    while (init_pending_n !== 1'b1 && n < 1000) begin
      @(negedge aclk);
      n++;
    end
  endtask : ready_wait
  task automatic rd(input logic [12:0] a, output logic [15:0] d,
                    output logic [1:0] oe);
    int n;
    n = 0;
    ready_wait();
    @(posedge aclk);
    addr <= a;
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (data_oe_n === 2'b11 && n < 30);
    d = data_o;
    oe = data_oe_n;
    repeat (2) @(posedge aclk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : rd
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    ready_wait();
    @(posedge aclk);
    addr <= a;
    wr_d <= d;
    drv <= 1'b1;
    ce_n <= 1'b0;
    we_n <= 1'b0;
    repeat (3) @(posedge aclk);
    we_n <= 1'b1;
    repeat (3) @(posedge aclk);
    ce_n <= 1'b1;
    drv <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : wr
endmodule : host_bus_model
`default_nettype wire

// *** verification/flash_disk_host_bus_width_endian_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_disk_host_bus_width_endian_tb;
  import host_port_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = 12'h000;
  logic [AXI_AW-1:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic strap = 1'b1;
  logic img_done = 1'b0;
  logic prot_done = 1'b0;
  logic [15:0] mem_rdata = 16'h0000;
  logic [15:0] data_o;
  logic [1:0] data_oe_n;
  logic pull_up_hi, init_pending_n;
  host_in_s host;
  mem_req_s mem, last_mem;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  always #4 aclk = ~aclk;

  host_port i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_i(host),
    .data_o(data_o), .data_oe_n(data_oe_n), .pull_up_hi(pull_up_hi),
    .init_pending_n(init_pending_n), .boot_code_image_done(img_done),
    .protection_structures_done(prot_done), .mem_o(mem),
    .mem_rdata(mem_rdata));

  host_bus_model i_host (.aclk(aclk), .strap(strap),
    .init_pending_n(init_pending_n), .pull_up_hi(pull_up_hi),
    .data_o(data_o), .data_oe_n(data_oe_n), .host_o(host));

  function automatic logic [15:0] wd(input logic [11:0] a);
    return {~a[7:0], a[7:0]};
  endfunction : wd

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
    if (mem.req) begin
      mem_rdata <= wd(mem.addr);
      last_mem <= mem;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Ready sampled at negedge: it is what the next rising edge sees
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic s_aw, s_w, s_b;
    s_b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!s_b) begin
      @(negedge aclk);
      s_aw = awvalid & awready;
      s_w = wvalid & wready;
      s_b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (s_aw) awvalid <= 1'b0;
      if (s_w) wvalid <= 1'b0;
      if (s_b) bready <= 1'b0;
    end
    chk("bresp", 32'(r), 32'(RESP_OKAY));
  endtask : axi_wr

  task automatic reg_chk(input logic [11:0] a, input logic [31:0] e,
                         input logic [1:0] er);
    logic s_ar, s_r;
    s_r = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!s_r) begin
      @(negedge aclk);
      s_ar = arvalid & arready;
      s_r = rvalid;
      if (s_r) begin
        chk("rdata", rdata, e);
        chk("rresp", 32'(rresp), 32'(er));
      end
      @(posedge aclk);
      if (s_ar) arvalid <= 1'b0;
      if (s_r) rready <= 1'b0;
    end
  endtask : reg_chk

  task automatic hr_chk(input logic [12:0] a, input logic [15:0] e,
                        input logic [1:0] eo);
    logic [15:0] d;
    logic [1:0] oe;
    i_host.rd(a, d, oe);
    chk("host data", 32'(d & {{8{~eo[1]}}, {8{~eo[0]}}}), 32'(e));
    chk("lane enables", 32'(oe), 32'(eo));
  endtask : hr_chk

  task automatic reset_dev(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    img_done <= 1'b1;
    @(posedge aclk);
    img_done <= 1'b0;
    repeat (6) @(negedge aclk);
    chk("init pending", 32'(init_pending_n), 32'h0);
    @(posedge aclk);
    prot_done <= 1'b1;
    @(posedge aclk);
    prot_done <= 1'b0;
    repeat (4) @(negedge aclk);
    chk("init pending", 32'(init_pending_n), 32'h1);
  endtask : reset_dev

  initial begin
    reset_dev(1'b1);
    reg_chk(ADDR_STATUS, 32'h2, RESP_OKAY);
    reg_chk(12'h008, 32'h0, RESP_SLVERR);
    hr_chk(13'h024, 16'hED12, 2'b00);
    chk("fetch lanes", 32'(last_mem.be), 32'h3);
    axi_wr(ADDR_ENDIAN_CTRL, 32'h1);
    hr_chk(13'h024, 16'hED12, 2'b00);
    axi_wr(ADDR_ENDIAN_CTRL, 32'h3);
    reg_chk(ADDR_ENDIAN_CTRL, 32'h3, RESP_OKAY);
    reg_chk(ADDR_STATUS, 32'hA, RESP_OKAY);
    hr_chk(13'h024, 16'h12ED, 2'b00);
    hr_chk(13'h025, 16'h0000, 2'b11);
    reg_chk(ADDR_STATUS, 32'hE, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h4);
    reg_chk(ADDR_STATUS, 32'hA, RESP_OKAY);
    $display("word mode test done");
    reset_dev(1'b0);
    chk("pull up", 32'(pull_up_hi), 32'h1);
    reg_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    hr_chk(13'h024, 16'h0012, 2'b10);
    hr_chk(13'h025, 16'h00ED, 2'b10);
    i_host.wr(13'h031, 16'h0077);
    chk("write lanes", 32'(last_mem.be), 32'h2);
    chk("write data", 32'(last_mem.wdata), 32'h7777);
    chk("write addr", 32'(last_mem.addr), 32'h018);
    $display("byte mode test done");
    final_report();
  end
endmodule : flash_disk_host_bus_width_endian_tb
`default_nettype wire
